// file: common/bao_pkg.sv
// Package: operation codes, widths, flag positions and reset values
package bao_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int PC_W = 15;
   localparam int BIT_W = 3;
   localparam int OFS_W = 9;
   localparam int NIBBLE_MSB = 3;
   localparam logic [7:0] RESET_ACC = 8'h00;
   localparam logic [14:0] RESET_PC = 15'h0000;
   localparam logic [14:0] PC_STEP = 15'h0001;

   // ---------------------------------------------------------------
   // Operations executed by this slice
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      BAO_OP_NONE = 3'b000,
      BAO_OP_SUM = 3'b001,
      BAO_OP_SUMC = 3'b010,
      BAO_OP_SHR = 3'b011,
      BAO_OP_CLR = 3'b100,
      BAO_OP_SKIPZ = 3'b101,
      BAO_OP_JUMP = 3'b110
   } bao_op_t;

   typedef enum logic [0:0] {
      BAO_ST_EXEC = 1'b0,
      BAO_ST_FLUSH = 1'b1
   } bao_state_t;

   // Decoded instruction as presented by the fetch/decode stage
   typedef struct packed {
      bao_op_t op;
      logic [6:0] addr;
      logic dest_to_location;
      logic [2:0] bit_pos;
      logic [8:0] offset;
   } bao_instr_t;

   // Status flags
   typedef struct packed {
      logic zero;
      logic nibble_overflow_bit;
      logic carry;
   } bao_flags_t;

   localparam bao_flags_t RESET_FLAGS = 3'h0;

   // Pure combinational result of one operation
   typedef struct packed {
      logic [7:0] value;
      logic write_acc;
      logic write_loc;
      bao_flags_t flags;
   } bao_result_t;
endpackage : bao_pkg

// file: verilog/bao_alu.sv
// Combinational datapath: arithmetic, shift and bit operations
`timescale 1ns/100ps
`default_nettype none
module bao_alu (
   // Operation
   input wire bao_pkg::bao_instr_t instr,
   // Operands
   input wire logic [7:0] acc,
   input wire logic [7:0] loc,
   input wire bao_pkg::bao_flags_t flags_in,
   // Result
   output bao_pkg::bao_result_t result
);
   import bao_pkg::*;

   logic [8:0] sum_full;
   logic [4:0] sum_low;
   logic carry_in;

   always_comb begin
      carry_in = (instr.op == BAO_OP_SUMC) ? flags_in.carry : 1'b0;
      sum_full = {1'b0, acc} + {1'b0, loc} + {8'h00, carry_in};
      sum_low = {1'b0, acc[3:0]} + {1'b0, loc[3:0]} + {4'h0, carry_in};
      result = '0;
      result.flags = flags_in;
      case (instr.op)
         BAO_OP_SUM, BAO_OP_SUMC: begin
            result.value = sum_full[7:0];
            result.flags.carry = sum_full[8];
            result.flags.nibble_overflow_bit = sum_low[4];
            result.flags.zero = (sum_full[7:0] == 8'h00);
            result.write_acc = ~instr.dest_to_location;
            result.write_loc = instr.dest_to_location;
         end
         BAO_OP_SHR: begin
            result.value = {loc[7], loc[7:1]};
            result.flags.carry = loc[0];
            result.flags.zero = ({loc[7], loc[7:1]} == 8'h00);
            result.write_acc = ~instr.dest_to_location;
            result.write_loc = instr.dest_to_location;
         end
         BAO_OP_CLR: begin
            // Flags left as they were
            result.value = loc & ~(8'h01 << instr.bit_pos);
            result.write_loc = 1'b1;
         end
         default: begin
            result.value = 8'h00;
         end
      endcase
   end
endmodule // bao_alu
`default_nettype wire

// file: verilog/bao_core_slice.sv
// Execution slice: accumulator, data memory, flags, program counter
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------------
// What this block does
// - Sum adds accumulator and location 0..127, sets all three flags.
// - Destination 0 writes the accumulator, 1 writes the location.
// - Shift right keeps bit 7, 7:1 to 6:0, bit 0 to carry, sets zero.
// - Sum with carry in also adds the carry, flags set, dest honoured.
// - Bit clear zeroes one location bit, other bits and flags kept.
// - Skip if zero discards the next word when the bit is 0, no flags.
// - Relative jump loads counter plus one plus 9-bit offset, no flags.
// - Relative jump takes two cycles, abandoning the fetched word.
// - A counter change or taken skip costs a second no-op cycle.
// ------------------------------------------------------------------
module bao_core_slice (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Instruction stream, one per cycle, from the same clock domain
   input wire bao_pkg::bao_instr_t instr,
   input wire logic instr_valid,
   // Architectural state
   output logic [7:0] accumulator,
   output bao_pkg::bao_flags_t flags,
   output logic [14:0] program_counter,
   // Cycle status
   output logic flush_cycle,
   output logic retired
);
   import bao_pkg::*;

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   logic [7:0] data_mem [0:127];
   logic [7:0] loc;
   bao_result_t result;
   bao_state_t state;
   logic exec;
   logic skip_taken;
   logic [14:0] jump_target;
   logic [14:0] pc_plus_one;

   // Pipeline drain slot is never a real instruction
   assign exec = instr_valid && (state == BAO_ST_EXEC);
   assign loc = data_mem[instr.addr];
   assign skip_taken = (instr.op == BAO_OP_SKIPZ) &&
                       (loc[instr.bit_pos] == 1'b0);
   assign pc_plus_one = program_counter + PC_STEP;
   // Offset sign-extended; range -256..255 wraps within the counter
   assign jump_target = pc_plus_one +
                        {{(PC_W - OFS_W){instr.offset[8]}}, instr.offset};

   bao_alu u_alu (
      .instr(instr),
      .acc(accumulator),
      .loc(loc),
      .flags_in(flags),
      .result(result)
   );

   // ---------------------------------------------------------------
   // Two-cycle sequencing
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         state <= BAO_ST_EXEC;
      end else begin
         case (state)
            BAO_ST_EXEC: begin
               if (exec && (skip_taken || instr.op == BAO_OP_JUMP)) begin
                  state <= BAO_ST_FLUSH;
               end
            end
            BAO_ST_FLUSH: begin
               // Fetched word discarded, slot runs as a no-op
               if (instr_valid) begin
                  state <= BAO_ST_EXEC;
               end
            end
            default: begin
               state <= BAO_ST_EXEC;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         flush_cycle <= 1'b0;
         retired <= 1'b0;
      end else begin
         flush_cycle <= instr_valid && (state == BAO_ST_FLUSH);
         retired <= exec;
      end
   end

   // ---------------------------------------------------------------
   // Program counter
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         program_counter <= RESET_PC;
      end else if (instr_valid) begin
         if (exec && instr.op == BAO_OP_JUMP) begin
            program_counter <= jump_target;
         end else begin
            program_counter <= pc_plus_one;
         end
      end
   end

   // ---------------------------------------------------------------
   // Accumulator and flags
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         accumulator <= RESET_ACC;
      end else if (exec && result.write_acc) begin
         accumulator <= result.value;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         flags <= RESET_FLAGS;
      end else if (exec) begin
         // Skip, jump and clear pass flags through unchanged
         flags <= result.flags;
      end
   end

   // ---------------------------------------------------------------
   // Data memory: contents are not reset, as in a real register file
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (exec && result.write_loc) begin
         data_mem[instr.addr] <= result.value;
      end
   end
endmodule // bao_core_slice
`default_nettype wire

// file: verif/bao_core_slice_monitor.sv
// Checker for the execution slice ports
`timescale 1ns/100ps
`default_nettype none
module bao_core_slice_monitor (
   // Inputs
   input wire logic core_clk,
   input wire logic resetn,
   input wire bao_pkg::bao_instr_t instr,
   input wire logic instr_valid,
   // Outputs
   input wire logic [7:0] accumulator,
   input wire bao_pkg::bao_flags_t flags,
   input wire logic [14:0] program_counter,
   input wire logic flush_cycle,
   input wire logic retired
);
   import bao_pkg::*;
   logic [14:0] ofs_x;
   logic [2:0] op;
   assign ofs_x = {{6{instr.offset[8]}}, instr.offset};
   // Idle cycles read as no operation
   assign op = instr_valid ? instr.op : 3'h0;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   a_jump_pc_load: assert property (retired && $past(op) == BAO_OP_JUMP
      |-> program_counter == $past(program_counter) + PC_STEP + $past(ofs_x))
      else $error("jump target wrong");
   a_jump_flags_kept: assert property (retired
      && $past(op) == BAO_OP_JUMP |-> flags == $past(flags))
      else $error("jump changed flags");
   a_jump_then_flush: assert property (op == BAO_OP_JUMP
      ##1 (retired && instr_valid) |=> flush_cycle && !retired)
      else $error("word after jump not discarded");
   a_pc_step_one: assert property (flush_cycle
      || retired && $past(op) != BAO_OP_JUMP
      |-> program_counter == $past(program_counter) + PC_STEP)
      else $error("pc step wrong");
   a_clear_flags_kept: assert property (retired
      && $past(op) == BAO_OP_CLR |-> flags == $past(flags))
      else $error("clear changed flags");
   a_skip_flags_kept: assert property (retired
      && $past(op) == BAO_OP_SKIPZ |-> flags == $past(flags))
      else $error("skip changed flags");
   a_zero_flag_acc: assert property (retired
      && $past(op) inside {BAO_OP_SUM, BAO_OP_SUMC, BAO_OP_SHR}
      && !$past(instr.dest_to_location)
      |-> flags.zero == (accumulator == 8'h00))
      else $error("zero flag wrong");
   a_dest_loc_acc: assert property (retired
      && $past(op) inside {BAO_OP_SUM, BAO_OP_SUMC, BAO_OP_SHR}
      && $past(instr.dest_to_location)
      |-> accumulator == $past(accumulator))
      else $error("accumulator written for location");
   c_jump: cover property (op == BAO_OP_JUMP ##1 retired);
   c_flush: cover property (flush_cycle);
   c_sum: cover property (op == BAO_OP_SUM ##1 retired);
endmodule // bao_core_slice_monitor
bind bao_core_slice bao_core_slice_monitor u_mon (.core_clk(core_clk),
   .resetn(resetn), .instr(instr), .instr_valid(instr_valid),
   .accumulator(accumulator), .flags(flags),
   .program_counter(program_counter), .flush_cycle(flush_cycle),
   .retired(retired));
`default_nettype wire

// file: verif/test_byte_alu_bit_and_branch_ops.sv
// Self-checking bench for the execution slice
`timescale 1ns/100ps
`default_nettype none
module test_byte_alu_bit_and_branch_ops;
   import bao_pkg::*;
   logic core_clk, resetn, instr_valid, flush_cycle, retired;
   bao_instr_t instr;
   logic [7:0] accumulator;
   bao_flags_t flags;
   logic [14:0] program_counter, pc0;
   int n_errors = 0;
   int tests_run = 0;
   bao_core_slice DUT (.core_clk(core_clk), .resetn(resetn), .instr(instr),
      .instr_valid(instr_valid), .accumulator(accumulator), .flags(flags),
      .program_counter(program_counter), .flush_cycle(flush_cycle),
      .retired(retired));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   task automatic chk(input logic ok);
      tests_run++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("BAD %0t: mismatch", $time);
      end
   endtask
   // Word at falling edge, taken at the next rising edge
   task automatic go(input bao_op_t op, input logic [8:0] ofs = 9'h000,
      input logic [2:0] b = 3'h0, input logic d = 1'b0);
      instr = '{op, 7'h05, d, b, ofs};
      instr_valid = 1'b1;
      @(negedge core_clk);
   endtask
   task automatic idle;
      instr_valid = 1'b0;
      @(negedge core_clk);
   endtask
   task automatic t_reset;
      chk(accumulator === RESET_ACC && program_counter === RESET_PC);
      chk(flags === RESET_FLAGS && retired === 1'b0);
      $display("t_reset done");
   endtask
   // Memory powers up unknown, so clear every bit of location 5 first
   task automatic t_arith;
      for (int i = 0; i < 8; i++)
         go(BAO_OP_CLR, 9'h000, 3'(i));
      chk(flags === RESET_FLAGS && retired === 1'b1);
      chk(program_counter === 15'h0008);
      go(BAO_OP_SUM);
      chk(accumulator === 8'h00 && flags === 3'h4);
      go(BAO_OP_CLR, 9'h000, 3'h7);
      chk(flags === 3'h4);
      go(BAO_OP_SUMC, 9'h000, 3'h0, 1'b1);
      chk(accumulator === 8'h00 && flags === 3'h4);
      go(BAO_OP_SHR);
      chk(flags === 3'h4);
      $display("t_arith done");
   endtask
   task automatic t_skip;
      pc0 = program_counter;
      go(BAO_OP_SKIPZ, 9'h000, 3'h3);
      chk(flags === 3'h4 && program_counter === pc0 + 15'h0001);
      go(BAO_OP_JUMP, 9'h064);
      chk(flush_cycle === 1'b1 && retired === 1'b0);
      chk(program_counter === pc0 + 15'h0002);
      $display("t_skip done");
   endtask
   task automatic t_jump;
      logic [8:0] tbl [3] = '{9'h1FE, 9'h0FF, 9'h100};
      for (int i = 0; i < 3; i++) begin
         pc0 = program_counter + 15'h0001 + {{6{tbl[i][8]}}, tbl[i]};
         go(BAO_OP_JUMP, tbl[i]);
         chk(program_counter === pc0 && flags === 3'h4);
         go(BAO_OP_SUM);
         chk(program_counter === pc0 + 15'h0001);
         chk(flush_cycle === 1'b1 && retired === 1'b0);
      end
      $display("t_jump done");
   endtask
   task automatic t_idle;
      pc0 = program_counter;
      idle();
      idle();
      chk(program_counter === pc0 && retired === 1'b0);
      $display("t_idle done");
   endtask
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #100000;
      n_errors++;
      report_and_stop();
   end
   initial begin
      resetn = 1'b0;
      instr_valid = 1'b0;
      instr = '0;
      repeat (12) @(negedge core_clk);
      resetn = 1'b1;
      t_reset();
      t_arith();
      t_skip();
      t_jump();
      t_idle();
      report_and_stop();
   end
endmodule // test_byte_alu_bit_and_branch_ops
`default_nettype wire
